// ==== rtl/bpa_status_regs.v ====
// Overview of operation
// [RULE_01] parity error on a backplane transfer sets status bit 31.
// [RULE_02] any fault bit newly set pulses the fault line one cycle.
// [RULE_03] write command without following write data sets bit 30; the code also accepts any next transfer carrying the command's ID.
// [RULE_04] read data arriving with no read outstanding sets bit 29.
// [RULE_05] bus ID differing from own while transmitting sets bit 27.
// [RULE_06] fault line seen two cycles after transmitting sets bit 26.
// [RULE_07] fault bits clear on fault line negation and on power-fail.
// [RULE_08] bits 28, 25-24, 21 and 20-08 of status read as zero.
// [RULE_09] AC-low assertion sets power-down bit 23; interrupts if enabled.
// [RULE_10] power-down clears on power-up, init, DC-low, bus_a, write one.
// [RULE_11] AC-low negation sets power-up bit 22, sets enable, interrupts.
// [RULE_12] power-up clears on power-down, init, DC-low, bus_a, write one.
// [RULE_13] bits 07-00 of status hold a fixed read-only adapter code.
// [RULE_14] writes to fault bits and code are ignored; 22-23 write-one-clear.
// [RULE_15] control bits 31-16 read zero and ignore writes.
`timescale 1ns/100ps
`default_nettype none
`include "bpa_regs.vh"

module bpa_status_regs #(
   parameter       ID_W         = 5,
   // arbitrary adapter code value
   parameter [7:0] ADAPTER_CODE = 8'h5a
)(
   // clock and reset
   input  wire            clk,
   input  wire            rst,
   // backplane transfer sensed this cycle
   input  wire            bp_valid,
   input  wire [2:0]      bp_tag,
   input  wire [ID_W-1:0] bp_id,
   input  wire [31:0]     bp_data,
   input  wire            bp_par,
   input  wire            bp_wr_cmd,
   input  wire            bp_to_me,
   // backplane fault line
   input  wire            bp_fault_in,
   output wire            bp_fault_out,
   // own transmit activity
   input  wire [ID_W-1:0] own_id,
   input  wire            tx_active,
   input  wire            rd_issue,
   // power and bus_a indications
   input  wire            ac_low_indication,
   input  wire            dc_low_indication,
   input  wire            bus_a,
   // register port
   input  wire            reg_cs,
   input  wire            reg_we,
   input  wire [7:0]      reg_addr,
   input  wire [31:0]     reg_wdata,
   output wire [31:0]     reg_rdata,
   output wire            reg_ack,
   // control outputs
   output wire            adapter_init,
   output wire            adapter_abort,
   output wire            maint_mode,
   output wire            irq
);

   // synchronised power indications
   wire [1:0]      pwr_s;
   wire            ac_low_s;
   wire            dc_low_s;
   wire [0:0]      ac_rise;
   wire [0:0]      ac_fall;

   // fault status flags
   reg             par_q;
   reg             miss_wr_q;
   reg             stray_rd_q;
   reg             dup_tx_q;
   reg             tx_flt_q;
   reg             par_d;
   reg             miss_wr_d;
   reg             stray_rd_d;
   reg             dup_tx_d;
   reg             tx_flt_d;

   // transfer tracking
   reg             wr_pend_q;
   reg [ID_W-1:0]  wr_id_q;
   reg             rd_out_q;
   reg             tx_d1_q;
   reg             tx_d2_q;
   reg             fault_prev_q;
   reg             fault_out_q;

   // power flags and control
   reg             pwr_dn_q;
   reg             pwr_up_q;
   reg             int_en_q;
   reg             abort_q;
   reg             maint_q;
   reg             init_q;
   reg             irq_q;
   reg             pwr_dn_d;
   reg             pwr_up_d;
   reg             int_en_d;
   reg             abort_d;
   reg             maint_d;
   reg             init_d;

   // register port answer
   reg [31:0]      rdata_q;
   reg [31:0]      rdata_d;
   reg             ack_q;

   // event terms
   wire            set_par;
   wire            set_miss_wr;
   wire            set_stray_rd;
   wire            set_dup_tx;
   wire            set_tx_flt;
   wire            clr_fault;
   wire            fault_neg;
   wire            wr_cmd_seen;
   wire            wr_data_ok;
   wire            rd_data_mine;
   wire            any_new;
   wire            wr_csr;
   wire            wr_cr;
   wire            clr_pwr;
   wire [31:0]     csr_val;
   wire [31:0]     cr_val;

   bpa_sync #(
      .W        (2)
   ) u_sync (
      .clk      (clk),
      .rst      (rst),
      .async_in ({dc_low_indication, ac_low_indication}),
      .sync_out (pwr_s)
   );

   assign ac_low_s = pwr_s[0];
   assign dc_low_s = pwr_s[1];

   bpa_edge #(
      .W    (1)
   ) u_ac_edge (
      .clk  (clk),
      .rst  (rst),
      .lvl  (ac_low_s),
      .rise (ac_rise),
      .fall (ac_fall)
   );

   // fault detection
   assign set_par = bp_valid
                    & ~(^{bp_par, bp_tag, bp_id, bp_data});   // [RULE_01]

   assign wr_cmd_seen = bp_valid & (bp_tag == `BPA_TAG_CMD)
                        & bp_wr_cmd & bp_to_me;
   assign wr_data_ok  = bp_valid & ((bp_tag == `BPA_TAG_WDATA)
                        | (bp_id == wr_id_q));
   assign set_miss_wr = wr_pend_q & ~wr_data_ok;            // [RULE_03]

   assign rd_data_mine = bp_valid & (bp_tag == `BPA_TAG_RDATA)
                         & (bp_id == own_id);
   assign set_stray_rd = rd_data_mine & ~rd_out_q;          // [RULE_04]

   assign set_dup_tx = tx_active & (bp_id != own_id);       // [RULE_05]
   assign set_tx_flt = tx_d2_q & bp_fault_in;               // [RULE_06]

   // negation of the fault line, or power-fail
   assign fault_neg = fault_prev_q & ~bp_fault_in;
   assign clr_fault = fault_neg | dc_low_s;                 // [RULE_07]

   assign any_new = (set_par & ~par_q) | (set_miss_wr & ~miss_wr_q)
                    | (set_stray_rd & ~stray_rd_q) | (set_dup_tx & ~dup_tx_q)
                    | (set_tx_flt & ~tx_flt_q);             // [RULE_02]

   // set wins over clear on every flag
   always @*
   begin
      par_d      = set_par      | (par_q      & ~clr_fault);
      miss_wr_d  = set_miss_wr  | (miss_wr_q  & ~clr_fault);
      stray_rd_d = set_stray_rd | (stray_rd_q & ~clr_fault);
      dup_tx_d   = set_dup_tx   | (dup_tx_q   & ~clr_fault);
      tx_flt_d   = set_tx_flt   | (tx_flt_q   & ~clr_fault);
   end

   // register port decode
   assign wr_csr = reg_cs & reg_we & (reg_addr == `BPA_CSR_OFS);
   assign wr_cr  = reg_cs & reg_we & (reg_addr == `BPA_CR_OFS);

   assign clr_pwr = init_q | dc_low_s | bus_a;

   // power flags and control register
   always @*
   begin
      pwr_dn_d = ac_rise[0]
             | (pwr_dn_q & ~(ac_fall[0] | clr_pwr
             | (wr_csr & reg_wdata[`BPA_CSR_DN_BIT]))); // [RULE_09] [RULE_10]
      pwr_up_d = ac_fall[0]
             | (pwr_up_q & ~(ac_rise[0] | clr_pwr
             | (wr_csr & reg_wdata[`BPA_CSR_UP_BIT]))); // [RULE_11] [RULE_12]
      int_en_d = int_en_q;
      abort_d  = abort_q;
      maint_d  = maint_q;
      init_d   = 1'b0;
      if (wr_cr)
      begin
         int_en_d = reg_wdata[`BPA_CR_INTEN_BIT];
         abort_d  = reg_wdata[`BPA_CR_ABORT_BIT];
         maint_d  = reg_wdata[`BPA_CR_MAINT_BIT];
         init_d   = reg_wdata[`BPA_CR_INIT_BIT];
      end
      if (ac_fall[0])
         int_en_d = 1'b1;                                   // [RULE_11]
   end

   // read values; unlisted bits are zero
   assign csr_val = {par_q, miss_wr_q, stray_rd_q, 1'b0,
                     dup_tx_q, tx_flt_q, 2'b00,
                     pwr_dn_q, pwr_up_q, 1'b0,
                     13'h0000,                              // [RULE_08]
                     ADAPTER_CODE};                         // [RULE_13]
   assign cr_val  = {16'h0000, 12'h000,                     // [RULE_15]
                     maint_q, int_en_q, abort_q, init_q};

   always @*
   begin
      rdata_d = `BPA_RDATA_RESET;
      if (reg_cs & ~reg_we)
      begin
         case (reg_addr)
            `BPA_CSR_OFS: rdata_d = csr_val;
            `BPA_CR_OFS:  rdata_d = cr_val;
            default:      rdata_d = `BPA_RDATA_RESET;
         endcase
      end
   end

   // transfer tracking
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_pend_q    <= 1'b0;
         wr_id_q      <= {ID_W{1'b0}};
         rd_out_q     <= 1'b0;
         tx_d1_q      <= 1'b0;
         tx_d2_q      <= 1'b0;
         fault_prev_q <= 1'b0;
      end
      else
      begin
         wr_pend_q    <= wr_cmd_seen;
         if (wr_cmd_seen)
            wr_id_q   <= bp_id;
         if (rd_issue)
            rd_out_q  <= 1'b1;
         else if (rd_data_mine)
            rd_out_q  <= 1'b0;
         tx_d1_q      <= tx_active;
         tx_d2_q      <= tx_d1_q;                           // [RULE_06]
         fault_prev_q <= bp_fault_in;
      end
   end

   // fault flags and fault pulse; writes never touch them
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         par_q       <= 1'b0;
         miss_wr_q   <= 1'b0;
         stray_rd_q  <= 1'b0;
         dup_tx_q    <= 1'b0;
         tx_flt_q    <= 1'b0;
         fault_out_q <= 1'b0;
      end
      else
      begin
         par_q       <= par_d;                              // [RULE_14]
         miss_wr_q   <= miss_wr_d;
         stray_rd_q  <= stray_rd_d;
         dup_tx_q    <= dup_tx_d;
         tx_flt_q    <= tx_flt_d;
         fault_out_q <= any_new;                            // [RULE_02]
      end
   end

   // power flags, control, interrupt
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pwr_dn_q <= 1'b0;
         pwr_up_q <= 1'b0;
         int_en_q <= 1'b0;
         abort_q <= 1'b0;
         maint_q <= 1'b0;
         init_q  <= 1'b0;
         irq_q   <= 1'b0;
      end
      else
      begin
         pwr_dn_q <= pwr_dn_d;
         pwr_up_q <= pwr_up_d;
         int_en_q <= int_en_d;
         abort_q <= abort_d;
         maint_q <= maint_d;
         init_q  <= init_d;
         irq_q   <= int_en_q & (pwr_dn_q | pwr_up_q);       // [RULE_09]
      end
   end

   // register port answer, one cycle after select
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rdata_q <= `BPA_RDATA_RESET;
         ack_q   <= 1'b0;
      end
      else
      begin
         rdata_q <= rdata_d;
         ack_q   <= reg_cs;
      end
   end

   assign bp_fault_out  = fault_out_q;
   assign reg_rdata     = rdata_q;
   assign reg_ack       = ack_q;
   assign adapter_init  = init_q;
   assign adapter_abort = abort_q;
   assign maint_mode    = maint_q;
   assign irq           = irq_q;

endmodule // bpa_status_regs

`default_nettype wire

// ==== rtl/bpa_regs.vh ====
`ifndef BPA_REGS_VH
`define BPA_REGS_VH

// register offsets (byte addresses)
`define BPA_CSR_OFS       8'h00
`define BPA_CR_OFS        8'h04

// configuration/status field positions
`define BPA_CSR_PAR_BIT   31
`define BPA_CSR_MISSWR_BIT 30
`define BPA_CSR_STRAY_BIT 29
`define BPA_CSR_DUPTX_BIT 27
`define BPA_CSR_TXFLT_BIT 26
`define BPA_CSR_DN_BIT    23
`define BPA_CSR_UP_BIT    22
`define BPA_CSR_CODE_MSB  7

// control field positions
`define BPA_CR_INIT_BIT   0
`define BPA_CR_ABORT_BIT  1
`define BPA_CR_INTEN_BIT  2
`define BPA_CR_MAINT_BIT  3

// reset values
`define BPA_CR_RESET      4'h0
`define BPA_RDATA_RESET   32'h0000_0000

// backplane transfer tags
`define BPA_TAG_RDATA     3'h0
`define BPA_TAG_CMD       3'h3
`define BPA_TAG_WDATA     3'h5

// timing: fault line sampled this many cycles after transmit
`define BPA_TXFLT_DELAY   2

`endif

// ==== rtl/bpa_sync.v ====
`timescale 1ns/100ps
`default_nettype none

// two-stage synchroniser, one per bit
module bpa_sync #(
   parameter W = 2
)(
   // clock and reset
   input  wire         clk,
   input  wire         rst,
   // asynchronous levels in, synchronised levels out
   input  wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1)
      begin : g_bit
         reg meta_q;
         reg stable_q;
         always @(posedge clk or posedge rst)
         begin
            if (rst)
            begin
               meta_q   <= 1'b0;
               stable_q <= 1'b0;
            end
            else
            begin
               meta_q   <= async_in[i];
               stable_q <= meta_q;
            end
         end
         assign sync_out[i] = stable_q;
      end
   endgenerate

endmodule // bpa_sync

`default_nettype wire

// ==== rtl/bpa_edge.v ====
`timescale 1ns/100ps
`default_nettype none

// rise and fall detection on synchronised levels
module bpa_edge #(
   parameter W = 1
)(
   // clock and reset
   input  wire         clk,
   input  wire         rst,
   // level in, one-cycle edge strobes out
   input  wire [W-1:0] lvl,
   output wire [W-1:0] rise,
   output wire [W-1:0] fall
);

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1)
      begin : g_bit
         reg prev_q;
         always @(posedge clk or posedge rst)
         begin
            if (rst)
               prev_q <= 1'b0;
            else
               prev_q <= lvl[i];
         end
         assign rise[i] = lvl[i] & ~prev_q;
         assign fall[i] = ~lvl[i] & prev_q;
      end
   endgenerate

endmodule // bpa_edge

`default_nettype wire

// ==== tb/bpa_status_regs_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module bpa_status_regs_chk #(
   parameter       ID_W         = 5,
   parameter [7:0] ADAPTER_CODE = 8'h5a
)(
   // clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // backplane
   input wire logic        bp_valid,
   input wire logic        bp_fault_in,
   input wire logic        bp_fault_out,
   input wire logic        tx_active,
   // register port
   input wire logic        reg_cs,
   input wire logic        reg_we,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic        reg_ack,
   // control outputs
   input wire logic        adapter_init,
   input wire logic        adapter_abort,
   input wire logic        maint_mode
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   wire rd0 = reg_cs & ~reg_we & (reg_addr == 8'h00);
   wire rd4 = reg_cs & ~reg_we & (reg_addr == 8'h04);
   wire wr4 = reg_cs & reg_we & (reg_addr == 8'h04);

   a_rsvd_stat_zero: assert property (
      $past(rd0) |-> reg_rdata[28] == 1'h0 && reg_rdata[25:24] == 2'h0
         && reg_rdata[21:8] == 14'h0000)
      else $error("reserved status bits not zero");
   a_code_fixed: assert property (
      $past(rd0) |-> reg_rdata[7:0] == ADAPTER_CODE)
      else $error("adapter code wrong");
   a_ctrl_upper_zero: assert property (
      $past(rd4) |-> reg_rdata[31:4] == 28'h000_0000)
      else $error("control upper bits not zero");
   a_ctrl_write_levels: assert property (
      $past(wr4) |-> adapter_abort == $past(reg_wdata[1])
         && maint_mode == $past(reg_wdata[3]))
      else $error("control levels not written");
   a_init_has_write: assert property (
      adapter_init |-> $past(wr4 && reg_wdata[0]))
      else $error("init pulse without write");
   a_fault_has_cause: assert property (
      bp_fault_out |-> $past(bp_valid) || $past(bp_valid, 2)
         || $past(tx_active) || $past(bp_fault_in))
      else $error("fault pulse without cause");
   a_ack_one_later: assert property (
      reg_cs |=> reg_ack)
      else $error("access not acknowledged");
   a_rdata_idle_zero: assert property (
      !reg_ack |-> reg_rdata == 32'h0000_0000)
      else $error("read data outside ack");
endmodule // bpa_status_regs_chk

bind bpa_status_regs bpa_status_regs_chk #(
   .ID_W         (ID_W),
   .ADAPTER_CODE (ADAPTER_CODE)
) u_chk (.*);
`default_nettype wire

// ==== tb/bpa_bp_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module bpa_bp_model #(
   parameter ID_W = 5
)(
   // clock
   input wire logic        clk,
   // backplane lines
   output logic            bp_valid,
   output logic [2:0]      bp_tag,
   output logic [ID_W-1:0] bp_id,
   output logic [31:0]     bp_data,
   output logic            bp_par,
   output logic            bp_wr_cmd,
   output logic            bp_to_me,
   output logic            bp_fault_in
);
   initial
   begin
      bp_valid = 1'h0;
      bp_tag = 3'h7;
      bp_id = '1;
      bp_data = 32'h1234_5678;
      bp_par = 1'h0;
      bp_wr_cmd = 1'h0;
      bp_to_me = 1'h0;
      bp_fault_in = 1'h0;
   end

   // one transfer cycle; bad flips the odd parity
   task xfer(input logic [2:0] tag, input logic [ID_W-1:0] id,
             input logic wr, input logic bad);
      @(posedge clk);
      bp_valid <= 1'h1;
      bp_tag <= tag;
      bp_id <= id;
      bp_data <= ~bp_data;
      bp_par <= bad ^ ~(^{tag, id, ~bp_data});
      bp_wr_cmd <= wr;
      bp_to_me <= 1'h1;
      @(posedge clk);
      // released lines show the inverse
      bp_valid <= 1'h0;
      bp_tag <= ~tag;
      bp_id <= ~id;
      bp_data <= ~bp_data;
      bp_wr_cmd <= ~wr;
      bp_to_me <= 1'h0;
   endtask

   task flt(input logic v);
      @(posedge clk);
      bp_fault_in <= v;
   endtask
endmodule // bpa_bp_model
`default_nettype wire

// ==== tb/test_bpa_status_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_bpa_status_regs;
   localparam [31:0] C = 32'h0000_005a;
   logic        clk, rst, bp_valid, bp_par, bp_wr_cmd, bp_to_me;
   logic        bp_fault_in, bp_fault_out, tx_active, rd_issue;
   logic        ac_low_indication, dc_low_indication, bus_a, irq;
   logic        reg_cs, reg_we, reg_ack, adapter_init;
   logic        adapter_abort, maint_mode;
   logic [2:0]  bp_tag;
   logic [4:0]  bp_id, own_id;
   logic [7:0]  reg_addr;
   logic [31:0] bp_data, reg_wdata, reg_rdata;
   int          err_count = 0;
   int          num_checks = 0;
   int          nflt = 0;

   bpa_status_regs u_dut (.*);
   bpa_bp_model u_bp (.*);

   initial
   begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk)
      if (bp_fault_out === 1'h1)
         nflt <= nflt + 1;

   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task acc(input logic [7:0] a, input logic we, input logic [31:0] d);
      @(posedge clk);
      reg_cs <= 1'h1;
      reg_we <= we;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_cs <= 1'h0;
      reg_we <= 1'h0;
      #1;
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e);
      acc(a, 1'h0, 32'h0000_0000);
      chk(reg_rdata, e);
   endtask

   // fault line pulse clears the fault bits
   task clr;
      u_bp.flt(1'h1);
      u_bp.flt(1'h0);
      @(posedge clk);
   endtask

   task tx_send(input logic [4:0] id);
      fork
         u_bp.xfer(3'h3, id, 1'h0, 1'h0);
         begin
            @(posedge clk);
            tx_active <= 1'h1;
            @(posedge clk);
            tx_active <= 1'h0;
         end
      join
   endtask

   task tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // whole run is well under 1000 cycles
   initial
   begin
      #20000;
      err_count++;
      tally_and_finish;
   end

   initial
   begin
      rst = 1'h1;
      reg_cs = 1'h0;
      reg_we = 1'h0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      own_id = 5'h01;
      tx_active = 1'h0;
      rd_issue = 1'h0;
      ac_low_indication = 1'h0;
      dc_low_indication = 1'h0;
      bus_a = 1'h0;
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      rd(8'h00, C);
      acc(8'h00, 1'h1, 32'hff7f_ffff);
      rd(8'h00, C);
      acc(8'h04, 1'h1, 32'hffff_fffa);
      rd(8'h04, 32'h0000_000a);
      rd(8'h08, 32'h0000_0000);
      acc(8'h04, 1'h1, 32'h0000_0000);
      $display("test registers done");
      u_bp.xfer(3'h5, 5'h02, 1'h0, 1'h1);
      rd(8'h00, C | 32'h8000_0000);
      clr;
      rd(8'h00, C);
      u_bp.xfer(3'h3, 5'h02, 1'h1, 1'h0);
      rd(8'h00, C | 32'h4000_0000);
      clr;
      u_bp.xfer(3'h0, 5'h01, 1'h0, 1'h0);
      rd(8'h00, C | 32'h2000_0000);
      clr;
      @(posedge clk);
      rd_issue <= 1'h1;
      @(posedge clk);
      rd_issue <= 1'h0;
      u_bp.xfer(3'h0, 5'h01, 1'h0, 1'h0);
      rd(8'h00, C);
      tx_send(5'h03);
      rd(8'h00, C | 32'h0800_0000);
      clr;
      tx_send(5'h01);
      u_bp.flt(1'h1);
      rd(8'h00, C | 32'h0400_0000);
      u_bp.flt(1'h0);
      @(posedge clk);
      rd(8'h00, C);
      chk(nflt, 32'h0000_0005);
      $display("test faults done");
      @(posedge clk);
      ac_low_indication <= 1'h1;
      repeat (4) @(posedge clk);
      rd(8'h00, C | 32'h0080_0000);
      chk(irq, 32'h0000_0000);
      acc(8'h00, 1'h1, 32'h0080_0000);
      rd(8'h00, C);
      @(posedge clk);
      ac_low_indication <= 1'h0;
      repeat (4) @(posedge clk);
      rd(8'h00, C | 32'h0040_0000);
      chk(irq, 32'h0000_0001);
      rd(8'h04, 32'h0000_0004);
      tx_send(5'h03);
      @(posedge clk);
      dc_low_indication <= 1'h1;
      repeat (4) @(posedge clk);
      dc_low_indication <= 1'h0;
      repeat (3) @(posedge clk);
      rd(8'h00, C);
      chk(irq, 32'h0000_0000);
      @(posedge clk);
      ac_low_indication <= 1'h1;
      repeat (4) @(posedge clk);
      rd(8'h00, C | 32'h0080_0000);
      chk(irq, 32'h0000_0001);
      @(posedge clk);
      bus_a <= 1'h1;
      @(posedge clk);
      bus_a <= 1'h0;
      rd(8'h00, C);
      @(posedge clk);
      ac_low_indication <= 1'h0;
      repeat (4) @(posedge clk);
      acc(8'h04, 1'h1, 32'h0000_0001);
      rd(8'h00, C);
      @(posedge clk);
      ac_low_indication <= 1'h1;
      repeat (4) @(posedge clk);
      rd(8'h00, C | 32'h0080_0000);
      @(posedge clk);
      ac_low_indication <= 1'h0;
      repeat (4) @(posedge clk);
      rd(8'h00, C | 32'h0040_0000);
      @(posedge clk);
      ac_low_indication <= 1'h1;
      repeat (4) @(posedge clk);
      rd(8'h00, C | 32'h0080_0000);
      acc(8'h04, 1'h1, 32'h0000_0001);
      rd(8'h00, C);
      $display("test power done");
      tally_and_finish;
   end
endmodule // test_bpa_status_regs
`default_nettype wire
